// [hw/adc_route_pkg.sv]
// package: offsets, field layout, reset values and decoded route types
package adc_route_pkg;
  // register addresses on the control bus (8-bit register index)
  localparam logic [7:0] LEFT_ROUTE_ADDR = 8'h15;
  localparam logic [7:0] RIGHT_ROUTE_ADDR = 8'h16;
  // field positions
  localparam int DIFF_BIT = 7;
  localparam int LEVEL_MSB = 6;
  localparam int LEVEL_LSB = 3;
  localparam int POWER_BIT = 2;
  localparam int STEP_MSB = 1;
  localparam int STEP_LSB = 0;
  // reset values
  localparam logic DIFF_RESET = 1'h0;
  localparam logic [3:0] LEVEL_RESET = 4'hf;
  localparam logic POWER_RESET = 1'h0;
  localparam logic [1:0] STEP_RESET = 2'h0;
  // level codes
  localparam logic [3:0] LEVEL_MAX_GAIN_CODE = 4'h8;
  localparam logic [3:0] LEVEL_OPEN_CODE = 4'hf;
  // reserved low bits of the left register
  localparam logic [2:0] LEFT_RSVD_VALUE = 3'h0;

  // soft-stepping modes
  typedef enum logic [1:0] {
    STEP_EVERY_SAMPLE,
    STEP_EVERY_TWO,
    STEP_OFF
  } step_mode_t;

  // decoded connection of the input pair to one mixer
  typedef struct packed {
    logic connected;    // pair feeds this mixer
    logic [3:0] atten;  // attenuation in 1.5 dB steps, 0..8
  } mix_route_t;

  // bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// [hw/level_decode.sv]
// level code decoder for one mixer path
`timescale 1ns/100ps
module level_decode
  import adc_route_pkg::*;
(
  // level field
  input wire logic [3:0] level_i,
  // decoded route
  output mix_route_t route_o
);
  // codes 0..8 connect with 1.5 dB steps; 1111 and reserved codes stay open
  always_comb begin
    route_o.connected = (level_i <= LEVEL_MAX_GAIN_CODE);
    route_o.atten = route_o.connected ? level_i : 4'h0;
  end
endmodule

// [hw/adc_input_route_regs.sv]
// control registers routing the right line-one input pair to both adc mixers
`timescale 1ns/100ps
module adc_input_route_regs
  import adc_route_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // register access, same clock domain
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_HIT_O,
  // analog controls for the left mixer path
  output logic LEFT_DIFF_O,
  output logic LEFT_CONNECT_O,
  output logic [3:0] LEFT_ATTEN_O,
  // analog controls for the right mixer path
  output logic RIGHT_DIFF_O,
  output logic RIGHT_CONNECT_O,
  output logic [3:0] RIGHT_ATTEN_O,
  output logic RIGHT_POWER_O,
  output step_mode_t RIGHT_STEP_O
);
  // timing in short:
  // a write strobe is taken at a rising edge and the fields change at that edge,
  // so the analog controls follow one cycle after the strobe is seen;
  // a read strobe loads the read register at its edge, and the value stands
  // until the next read, so a slow host can pick it up whenever it likes;
  // a write and a read in one cycle return the value from before the write

  // bundled bus request
  reg_req_t req; // bundled request
  // write decode per register
  logic left_wr; // write aimed at the left register
  logic right_wr; // write aimed at the right register
  // left register fields
  logic left_diff_reg; // left register mode bit
  logic [3:0] left_level_reg; // left level field
  // right register fields
  logic right_diff_reg; // right register mode bit
  logic [3:0] right_level_reg; // right level field
  logic right_power_reg; // right channel power
  logic [1:0] right_step_reg; // soft-step code
  // read path
  logic [7:0] left_image; // left register as software sees it
  logic [7:0] right_image; // right register as software sees it
  logic [7:0] rdata_next; // read mux
  // decoded mixer paths
  mix_route_t left_route; // decoded left path
  mix_route_t right_route; // decoded right path

  // address match, used for both write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // gather the bus signals
  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};

  // write decode; other addresses are ignored without any error
  assign left_wr = req.wr && hit(req.addr, LEFT_ROUTE_ADDR);
  assign right_wr = req.wr && hit(req.addr, RIGHT_ROUTE_ADDR);

  // left mode bit
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      // single-ended after reset
      left_diff_reg <= DIFF_RESET;
    end else if (left_wr) begin
      // new mode applies from the next cycle
      left_diff_reg <= req.wdata[DIFF_BIT];
    end
  end

  // left level field; reserved low bits are simply not stored
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      // disconnected after reset
      left_level_reg <= LEVEL_RESET;
    end else if (left_wr) begin
      // reserved codes are kept as written, the decoder leaves them open
      left_level_reg <= req.wdata[LEVEL_MSB:LEVEL_LSB];
    end
  end

  // right mode bit; not forced equal to the left one, that is software's job
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      // single-ended after reset
      right_diff_reg <= DIFF_RESET;
    end else if (right_wr) begin
      // new mode applies from the next cycle
      right_diff_reg <= req.wdata[DIFF_BIT];
    end
  end

  // right level field
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      // disconnected after reset
      right_level_reg <= LEVEL_RESET;
    end else if (right_wr) begin
      // same encoding as the left field
      right_level_reg <= req.wdata[LEVEL_MSB:LEVEL_LSB];
    end
  end

  // right channel power
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      // powered down after reset
      right_power_reg <= POWER_RESET;
    end else if (right_wr) begin
      // set powers up, clear powers down
      right_power_reg <= req.wdata[POWER_BIT];
    end
  end

  // right soft-step code, stored raw so a read returns what was written
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      // step every sample after reset
      right_step_reg <= STEP_RESET;
    end else if (right_wr) begin
      // decoded into a mode further down
      right_step_reg <= req.wdata[STEP_MSB:STEP_LSB];
    end
  end

  // register images; reserved left bits are constant zero
  assign left_image = {left_diff_reg, left_level_reg, LEFT_RSVD_VALUE};
  assign right_image = {right_diff_reg, right_level_reg, right_power_reg, right_step_reg};

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (hit(req.addr, LEFT_ROUTE_ADDR)) begin
      // left routing register
      rdata_next = left_image;
    end else if (hit(req.addr, RIGHT_ROUTE_ADDR)) begin
      // right routing register
      rdata_next = right_image;
    end
  end

  // read data registered, one cycle after the read strobe
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (req.rd) begin
      REG_RDATA_O <= rdata_next; // unmapped address reads zero
    end
  end

  // handshake: combinational address hit
  assign REG_HIT_O = hit(req.addr, LEFT_ROUTE_ADDR) || hit(req.addr, RIGHT_ROUTE_ADDR);

  // one decoder per mixer path; reserved codes leave the path open
  level_decode u_left_dec (
    .level_i(left_level_reg),
    .route_o(left_route)
  );
  level_decode u_right_dec (
    .level_i(right_level_reg),
    .route_o(right_route)
  );

  // analog controls; both modes are driven as stored, keeping them equal is software's job
  assign LEFT_DIFF_O = left_diff_reg;
  assign LEFT_CONNECT_O = left_route.connected;
  assign LEFT_ATTEN_O = left_route.atten;
  assign RIGHT_DIFF_O = right_diff_reg;
  assign RIGHT_CONNECT_O = right_route.connected;
  assign RIGHT_ATTEN_O = right_route.atten;
  assign RIGHT_POWER_O = right_power_reg;

  // step code: 10 and 11 both disable stepping
  always_comb begin
    case (right_step_reg)
      2'h0: RIGHT_STEP_O = STEP_EVERY_SAMPLE;
      2'h1: RIGHT_STEP_O = STEP_EVERY_TWO;
      default: RIGHT_STEP_O = STEP_OFF;
    endcase
  end
endmodule

// [sim/adc_route_monitor.sv]
// checker for the route register bank
`timescale 1ns/100ps
module adc_route_monitor
  import adc_route_pkg::*;
(
  // watched ports, several to a line to keep the file short
  input wire logic CLK_SYS_I, RESET_N_I, REG_WR_I, REG_RD_I,
  input wire logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O,
  input wire logic REG_HIT_O,
  input wire logic LEFT_DIFF_O, LEFT_CONNECT_O, RIGHT_CONNECT_O, RIGHT_POWER_O,
  input wire logic [3:0] LEFT_ATTEN_O,
  input wire step_mode_t RIGHT_STEP_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  // writes to each register, and a read of the right register
  sequence wl; REG_WR_I && REG_ADDR_I == 8'h15; endsequence
  sequence wr; REG_WR_I && REG_ADDR_I == 8'h16; endsequence
  sequence rr; REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h16; endsequence
  a_left_mode: assert property (wl |=> LEFT_DIFF_O == $past(REG_WDATA_I[7]))
    else $error("left mode wrong");
  a_left_gain: assert property ((wl and (REG_WDATA_I[6:3] <= 4'h8)) |=>
    LEFT_CONNECT_O && LEFT_ATTEN_O == $past(REG_WDATA_I[6:3])) else $error("left gain");
  a_left_open: assert property ((wl and (REG_WDATA_I[6:3] == 4'hf)) |=> !LEFT_CONNECT_O)
    else $error("left not open");
  a_rsvd_zero: assert property (REG_RD_I && REG_ADDR_I == 8'h15 |=> REG_RDATA_O[2:0] == 3'h0)
    else $error("reserved bits set");
  a_right_power: assert property (wr |=> RIGHT_POWER_O == $past(REG_WDATA_I[2]))
    else $error("power wrong");
  a_step_off: assert property ((wr and REG_WDATA_I[1]) |=> RIGHT_STEP_O == STEP_OFF)
    else $error("step not off");
  a_right_link: assert property (wr |=> RIGHT_CONNECT_O == ($past(REG_WDATA_I[6:3]) <= 4'h8))
    else $error("right connect");
  a_read_back: assert property (wr ##1 (!REG_WR_I)[*3] ##1 rr |=>
    REG_RDATA_O == $past(REG_WDATA_I, 5)) else $error("read back");
  a_hit_decode: assert property (REG_HIT_O == (REG_ADDR_I == 8'h15 || REG_ADDR_I == 8'h16))
    else $error("hit decode");
endmodule
bind adc_input_route_regs adc_route_monitor adc_route_monitor_i (.*);

// [sim/host_model.sv]
// host side: one strobe cycle per access, driven at the falling edge
`timescale 1ns/100ps
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o, rd_o,
  output logic [7:0] addr_o, wdata_o
);
  initial begin wr_o = 0; rd_o = 0; addr_o = 0; wdata_o = 0; end
  // idle lines show the inverse so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk_i); wr_o = w; rd_o = !w; addr_o = a; wdata_o = d;
    @(negedge clk_i); wr_o = 0; rd_o = 0; addr_o = ~a; wdata_o = ~d; q = rdata_i;
  endtask
endmodule

// [sim/adc_input_route_regs_tb_top.sv]
// bench: model-checked tests of the route register bank
`timescale 1ns/100ps
module adc_input_route_regs_tb_top;
  import adc_route_pkg::*;
  logic clk = 0, rst_n = 0, wr, rd, ld, lc, rdf, rc, rp;
  logic [7:0] ad, wd, rq, q, d;
  logic [3:0] la, ra;
  step_mode_t rs;
  int n_mismatch = 0, check_count = 0;
  bit [31:0] seed = 32'hafc0ec36;
  logic [7:0] m [2]; // model of both registers
  initial forever #5 clk = ~clk;
  host_model host_model_i (.clk_i(clk), .rdata_i(rq), .wr_o(wr), .rd_o(rd), .addr_o(ad), .wdata_o(wd));
  adc_input_route_regs adc_input_route_regs_i (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(ad), .REG_WDATA_I(wd), .REG_RDATA_O(rq),
    .REG_HIT_O(), .LEFT_DIFF_O(ld), .LEFT_CONNECT_O(lc), .LEFT_ATTEN_O(la),
    .RIGHT_DIFF_O(rdf), .RIGHT_CONNECT_O(rc), .RIGHT_ATTEN_O(ra),
    .RIGHT_POWER_O(rp), .RIGHT_STEP_O(rs));
  function automatic bit [31:0] xs();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; return seed;
  endfunction
  // expected mode, connect and attenuation of one register
  function automatic logic [7:0] ex(logic [7:0] r);
    return {2'h0, r[7], r[6:3] <= 4'h8, r[6:3] <= 4'h8 ? r[6:3] : 4'h0};
  endfunction
  task automatic chk(string s, logic [7:0] e, v);
    check_count++;
    if (v !== e) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", s, e, v); end
  endtask
  // read both registers back and compare every analog control output with the model
  task automatic audit();
    for (int i = 0; i < 2; i++) begin
      host_model_i.xfer(0, 8'h15 + i, 8'h00, q);
      chk("rdata", m[i], q);
    end
    chk("left", ex(m[0]), {2'h0, ld, lc, la});
    chk("right", ex(m[1]), {2'h0, rdf, rc, ra});
    chk("pwr_step", {5'h0, m[1][2], m[1][1] ? 2'h2 : {1'b0, m[1][0]}}, {5'h0, rp, rs});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    m = '{8'h78, 8'h78};
    repeat (12) @(negedge clk);
    rst_n = 1;
    audit();
    $display("reset values done");
    for (int k = 0; k < 40; k++) begin
      d = xs();
      // host never uses codes 9..14, keeps reserved bits zero, same mode
      m[0] = {d[7], k % 10 == 9 ? 4'hf : 4'(k % 10), 3'h0};
      m[1] = {d[7], (k + 3) % 10 == 9 ? 4'hf : 4'((k + 3) % 10), d[2], 2'(k)};
      host_model_i.xfer(1, 8'h15, m[0], q);
      host_model_i.xfer(1, 8'h16, m[1], q);
      audit();
    end
    $display("level sweep done");
    host_model_i.xfer(0, 8'h17, 8'h00, q);
    chk("unmapped", 8'h00, q);
    @(negedge clk) rst_n = 0;
    @(negedge clk) rst_n = 1;
    m = '{8'h78, 8'h78};
    audit();
    $display("second reset done");
    test_done();
  end
  initial begin #100000; n_mismatch++; test_done(); end
endmodule
